// >>> logic/issr_pkg.sv
// Package: character layout, indicator state, events and commands of the status save/restore unit
package issr_pkg;
    localparam int SEL_W = 6;
    localparam int RST_SEL_W = 5;
    localparam int RST_MAX = 5;
    // Selector bit index for each stored item, lowest stored first
    localparam logic [2:0] IDX_VARIANT = 3'h0;
    localparam logic [2:0] IDX_ARITH = 3'h1;
    localparam logic [2:0] IDX_AUX = 3'h2;
    localparam logic [2:0] IDX_SCI = 3'h3;
    localparam logic [2:0] IDX_PROT = 3'h4;
    localparam logic [2:0] IDX_SOURCE = 3'h5;
    // Address mode codes held in the B and A bits
    localparam logic [1:0] AM_TWO_CH = 2'h1;
    localparam logic [1:0] AM_THREE_CH = 2'h0;
    localparam logic [1:0] AM_FOUR_CH = 2'h3;

    typedef enum logic {
        ISSR_OP_SAVE = 1'b0,
        ISSR_OP_RESTORE = 1'b1
    } issr_op_type;

    typedef struct packed {
        issr_op_type op;
        logic [SEL_W-1:0] sel;
    } issr_cmd_type;

    // Item-mark bit, then B, A, 8, 4, 2, 1
    typedef struct packed {
        logic im;
        logic b;
        logic a;
        logic b8;
        logic b4;
        logic b2;
        logic b1;
    } issr_char_type;

    typedef struct packed {
        logic wm;
        issr_char_type ch;
    } issr_rchar_type;

    // Laid out exactly as the stored character
    typedef struct packed {
        logic trap;
        logic [1:0] addr_mode;
        logic overflow;
        logic zero_bal;
        logic a_le_b;
        logic a_eq_b;
    } issr_arith_type;

    typedef struct packed {
        logic [SEL_W-1:0] variant;
        issr_arith_type arith;
        issr_arith_type aux;
        logic ext_io;
        logic multiprog_flag_a;
        logic multiprog_flag_b;
        logic multiprog_flag_c;
        logic [2:0] sector_mask;
        logic protect;
        logic timeout_allow;
        logic s_mode;
        logic proceed;
        logic relocation;
        logic external_int_mode;
        logic internal_int_mode;
        logic ext_addr_viol;
        logic monitor_call;
        logic console_int;
        logic periph_int;
        logic int_addr_viol;
        logic opcode_viol;
        logic instr_timeout;
    } issr_ind_type;

    // All zero: three-character address mode encodes as zero
    localparam issr_ind_type IND_RESET = '0;

    typedef struct packed {
        logic ext_enter;
        logic int_enter;
        logic leave_ext;
        logic leave_int;
        logic arith_load;
        logic variant_load;
        logic ext_addr_viol;
        logic monitor_call;
        logic console_int;
        logic periph_int;
        logic int_addr_viol;
        logic opcode_viol;
        logic instr_timeout;
    } issr_evt_type;
endpackage : issr_pkg

// >>> logic/issr_unit.sv
// Status save/restore execution unit: indicator state and its memory sequencing
// What this block does
// - Save writes one character per set selector bit, never more.
// - Save writes lowest selector bit first, from selector address plus one.
// - Save fetch ends at selector plus one; resume at next word mark after data.
// - Save ignores and never alters word marks in target locations.
// - Unused item-mark and data bits of saved characters are zero.
// - Indicators absent in this configuration are saved as zero.
// - Arithmetic character: trap, address mode, overflow, zero, A<=B, A=B.
// - Scientific character: extended I/O, three multiprogram flags, three sector masks.
// - Protection character: protect, timeout allow, S-mode, proceed, relocation, II while in external mode.
// - External mode source: violation, monitor, console, peripheral, one, II mode.
// - Otherwise source: address violation, opcode violation, timeout, 0, 0, 1.
// - Clear-on-store indicators are cleared as their values are saved.
// - Internal interrupt does not copy arithmetic state into the auxiliary register.
// - Save leaves the variant register unchanged.
// - Restore loads at most five characters.
// - Restore reads ascending from the A operand address.
// - Only low five selector bits pick restored items; source never restored.
// - Restore reads one character per selected item only.
// - Leaving external mode copies auxiliary register into arithmetic indicators.
// - Protect and proceed turn on only by a restore with selector bit five.
// - Restore changes the variant register only when explicitly selected.
// - Restore neither tests nor modifies word marks.
`timescale 1ns/1ns
module issr_unit #(
    parameter int ADDR_W = 15,
    parameter bit HAS_PROTECT = 1'b1,
    parameter bit HAS_EXT_MP = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire issr_pkg::issr_cmd_type cmd_i,
    input wire logic [ADDR_W-1:0] sel_addr_i,
    input wire logic [ADDR_W-1:0] a_addr_i,
    input wire logic [ADDR_W-1:0] next_instr_i,
    input wire issr_pkg::issr_evt_type evt_i,
    input wire issr_pkg::issr_arith_type arith_val_i,
    input wire logic [issr_pkg::SEL_W-1:0] variant_val_i,
    input wire issr_pkg::issr_rchar_type mem_rdata_i,
    output logic busy_o,
    output logic done_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output issr_pkg::issr_char_type mem_wdata_o,
    output issr_pkg::issr_ind_type ind_o,
    output logic [ADDR_W-1:0] instr_sequence_reg_o
);
    if (ADDR_W < 4 || ADDR_W > 24) begin : g_bad_width
        $error("issr_unit: ADDR_W must lie in 4..24");
    end

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SAVE = 6'h02,
        ST_RD_REQ = 6'h04,
        ST_RD_WAIT = 6'h08,
        ST_RD_DATA = 6'h10,
        ST_DONE = 6'h20
    } issr_fsm_type;

    typedef struct packed {
        issr_fsm_type fsm;
        issr_pkg::issr_op_type op;
        logic [issr_pkg::SEL_W-1:0] sel;
        logic [issr_pkg::SEL_W-1:0] rem;
        logic [2:0] idx;
        logic [ADDR_W-1:0] ptr;
        logic [ADDR_W-1:0] sr;
        logic [ADDR_W-1:0] maddr;
        logic rd;
        logic wr;
        issr_pkg::issr_char_type wdata;
        issr_pkg::issr_ind_type ind;
    } issr_state_type;

    issr_state_type st_r;
    issr_state_type st_nxt;

    function automatic logic [2:0] lowest(input logic [issr_pkg::SEL_W-1:0] m);
        lowest = 3'h0;
        for (int i = issr_pkg::SEL_W - 1; i >= 0; i--) begin
            if (m[i]) begin
                lowest = 3'(i);
            end
        end
    endfunction : lowest

    // Character image of one item; bits with no meaning stay zero
    function automatic issr_pkg::issr_char_type save_char(input logic [2:0] idx,
                                                          input issr_pkg::issr_ind_type s);
        issr_pkg::issr_char_type c;
        c = '0;
        case (idx)
            issr_pkg::IDX_VARIANT: begin
                {c.b, c.a, c.b8, c.b4, c.b2, c.b1} = s.variant;
            end
            issr_pkg::IDX_ARITH: begin
                c = issr_pkg::issr_char_type'(s.arith);
            end
            issr_pkg::IDX_AUX: begin
                c = issr_pkg::issr_char_type'(s.aux);
            end
            issr_pkg::IDX_SCI: begin
                c.im = s.ext_io;
                c.b = s.multiprog_flag_a;
                c.a = s.multiprog_flag_b;
                c.b8 = s.multiprog_flag_c;
                {c.b4, c.b2, c.b1} = {s.sector_mask[0], s.sector_mask[1], s.sector_mask[2]};
            end
            issr_pkg::IDX_PROT: begin
                c.b = s.protect;
                c.a = s.timeout_allow;
                c.b8 = s.s_mode;
                c.b4 = s.proceed;
                c.b2 = s.relocation;
                c.b1 = s.external_int_mode & s.internal_int_mode;
            end
            issr_pkg::IDX_SOURCE: begin
                if (s.external_int_mode) begin
                    c.b = s.ext_addr_viol;
                    c.a = s.monitor_call;
                    c.b8 = s.console_int;
                    c.b4 = s.periph_int;
                    c.b2 = 1'b1;
                    c.b1 = s.internal_int_mode;
                end else begin
                    c.b = s.int_addr_viol;
                    c.a = s.opcode_viol;
                    c.b8 = s.instr_timeout;
                    c.b1 = 1'b1;
                end
            end
            default: begin
                c = '0;
            end
        endcase
        return c;
    endfunction : save_char

    always_comb begin
        st_nxt = st_r;
        st_nxt.wr = 1'b0;
        st_nxt.rd = 1'b0;
        unique case (st_r.fsm)
            ST_IDLE: begin
                if (start_i) begin
                    st_nxt.op = cmd_i.op;
                    st_nxt.sel = cmd_i.sel;
                    if (cmd_i.op == issr_pkg::ISSR_OP_SAVE) begin
                        st_nxt.rem = cmd_i.sel;
                        // Selector plus one holds the ending word mark and the first item
                        st_nxt.ptr = sel_addr_i + ADDR_W'(1);
                        st_nxt.fsm = ST_SAVE;
                    end else begin
                        // Selector bit six is ignored, so the source item never returns
                        st_nxt.rem = {1'b0, cmd_i.sel[issr_pkg::RST_SEL_W-1:0]};
                        st_nxt.ptr = a_addr_i;
                        st_nxt.sr = next_instr_i;
                        st_nxt.fsm = ST_RD_REQ;
                    end
                end
            end
            ST_SAVE: begin
                if (st_r.rem != '0) begin
                    st_nxt.idx = lowest(st_r.rem);
                    st_nxt.wr = 1'b1;
                    st_nxt.maddr = st_r.ptr;
                    st_nxt.wdata = save_char(st_nxt.idx, st_r.ind);
                    st_nxt.rem[st_nxt.idx] = 1'b0;
                    st_nxt.ptr = st_r.ptr + ADDR_W'(1);
                    // Clear-on-store indicators drop in the cycle their value is captured
                    unique case (st_nxt.idx)
                        issr_pkg::IDX_ARITH: begin
                            st_nxt.ind.arith.overflow = 1'b0;
                            st_nxt.ind.arith.zero_bal = 1'b0;
                            st_nxt.ind.arith.a_le_b = 1'b0;
                            st_nxt.ind.arith.a_eq_b = 1'b0;
                        end
                        issr_pkg::IDX_AUX: begin
                            st_nxt.ind.aux.overflow = 1'b0;
                            st_nxt.ind.aux.zero_bal = 1'b0;
                            st_nxt.ind.aux.a_le_b = 1'b0;
                            st_nxt.ind.aux.a_eq_b = 1'b0;
                        end
                        issr_pkg::IDX_SCI: begin
                            st_nxt.ind.multiprog_flag_a = 1'b0;
                            st_nxt.ind.multiprog_flag_b = 1'b0;
                            st_nxt.ind.multiprog_flag_c = 1'b0;
                        end
                        issr_pkg::IDX_PROT: begin
                            st_nxt.ind.protect = 1'b0;
                            st_nxt.ind.proceed = 1'b0;
                            st_nxt.ind.timeout_allow = 1'b0;
                        end
                        issr_pkg::IDX_SOURCE: begin
                            if (st_r.ind.external_int_mode) begin
                                st_nxt.ind.ext_addr_viol = 1'b0;
                                st_nxt.ind.console_int = 1'b0;
                            end else begin
                                st_nxt.ind.int_addr_viol = 1'b0;
                                st_nxt.ind.opcode_viol = 1'b0;
                                st_nxt.ind.instr_timeout = 1'b0;
                            end
                        end
                        default: begin
                            st_nxt.ind.variant = st_r.ind.variant;
                        end
                    endcase
                end else begin
                    st_nxt.fsm = ST_RD_REQ;
                end
            end
            ST_RD_REQ: begin
                if (st_r.op == issr_pkg::ISSR_OP_RESTORE && st_r.rem == '0) begin
                    st_nxt.fsm = ST_DONE;
                end else begin
                    st_nxt.rd = 1'b1;
                    st_nxt.maddr = st_r.ptr;
                    st_nxt.idx = lowest(st_r.rem);
                    st_nxt.fsm = ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: begin
                st_nxt.fsm = ST_RD_DATA;
            end
            ST_RD_DATA: begin
                st_nxt.fsm = ST_RD_REQ;
                st_nxt.ptr = st_r.ptr + ADDR_W'(1);
                if (st_r.op == issr_pkg::ISSR_OP_SAVE) begin
                    // The scan after the stored data looks only for the next op code
                    if (mem_rdata_i.wm) begin
                        st_nxt.sr = st_r.ptr;
                        st_nxt.ptr = st_r.ptr;
                        st_nxt.fsm = ST_DONE;
                    end
                end else begin
                    // Word mark of the restored location is neither checked nor written
                    st_nxt.rem[st_r.idx] = 1'b0;
                    unique case (st_r.idx)
                        issr_pkg::IDX_VARIANT: begin
                            st_nxt.ind.variant = {mem_rdata_i.ch.b, mem_rdata_i.ch.a,
                                mem_rdata_i.ch.b8, mem_rdata_i.ch.b4, mem_rdata_i.ch.b2,
                                mem_rdata_i.ch.b1};
                        end
                        issr_pkg::IDX_ARITH: begin
                            st_nxt.ind.arith = issr_pkg::issr_arith_type'(mem_rdata_i.ch);
                        end
                        issr_pkg::IDX_AUX: begin
                            st_nxt.ind.aux = issr_pkg::issr_arith_type'(mem_rdata_i.ch);
                        end
                        issr_pkg::IDX_SCI: begin
                            st_nxt.ind.ext_io = mem_rdata_i.ch.im;
                            st_nxt.ind.multiprog_flag_a = mem_rdata_i.ch.b;
                            st_nxt.ind.multiprog_flag_b = mem_rdata_i.ch.a;
                            st_nxt.ind.multiprog_flag_c = mem_rdata_i.ch.b8;
                            st_nxt.ind.sector_mask = {mem_rdata_i.ch.b1, mem_rdata_i.ch.b2,
                                mem_rdata_i.ch.b4};
                        end
                        default: begin
                            st_nxt.ind.protect = mem_rdata_i.ch.b;
                            st_nxt.ind.timeout_allow = mem_rdata_i.ch.a;
                            st_nxt.ind.s_mode = mem_rdata_i.ch.b8;
                            st_nxt.ind.proceed = mem_rdata_i.ch.b4;
                            st_nxt.ind.relocation = mem_rdata_i.ch.b2;
                            if (st_r.ind.external_int_mode) begin
                                st_nxt.ind.internal_int_mode = mem_rdata_i.ch.b1;
                            end
                        end
                    endcase
                end
            end
            ST_DONE: begin
                st_nxt.fsm = ST_IDLE;
            end
        endcase

        // Events come last so a set in the cycle of a store clear is kept
        if (evt_i.variant_load) begin
            st_nxt.ind.variant = variant_val_i;
        end
        if (evt_i.arith_load) begin
            st_nxt.ind.arith = arith_val_i;
        end
        if (evt_i.ext_enter) begin
            st_nxt.ind.aux = st_r.ind.arith;
            st_nxt.ind.external_int_mode = 1'b1;
        end
        if (evt_i.int_enter) begin
            st_nxt.ind.internal_int_mode = 1'b1;
        end
        if (evt_i.leave_ext) begin
            st_nxt.ind.arith = st_r.ind.aux;
            st_nxt.ind.external_int_mode = 1'b0;
            st_nxt.ind.monitor_call = 1'b0;
            st_nxt.ind.periph_int = 1'b0;
        end
        if (evt_i.leave_int) begin
            st_nxt.ind.internal_int_mode = 1'b0;
        end
        st_nxt.ind.ext_addr_viol = st_nxt.ind.ext_addr_viol | evt_i.ext_addr_viol;
        st_nxt.ind.monitor_call = st_nxt.ind.monitor_call | evt_i.monitor_call;
        st_nxt.ind.console_int = st_nxt.ind.console_int | evt_i.console_int;
        st_nxt.ind.periph_int = st_nxt.ind.periph_int | evt_i.periph_int;
        st_nxt.ind.int_addr_viol = st_nxt.ind.int_addr_viol | evt_i.int_addr_viol;
        st_nxt.ind.opcode_viol = st_nxt.ind.opcode_viol | evt_i.opcode_viol;
        st_nxt.ind.instr_timeout = st_nxt.ind.instr_timeout | evt_i.instr_timeout;

        // Absent features hold their indicators at zero, so they save as zero
        if (!HAS_PROTECT) begin
            st_nxt.ind.protect = 1'b0;
            st_nxt.ind.proceed = 1'b0;
        end
        if (!HAS_EXT_MP) begin
            st_nxt.ind.timeout_allow = 1'b0;
            st_nxt.ind.relocation = 1'b0;
            st_nxt.ind.ext_io = 1'b0;
            st_nxt.ind.multiprog_flag_a = 1'b0;
            st_nxt.ind.multiprog_flag_b = 1'b0;
            st_nxt.ind.multiprog_flag_c = 1'b0;
            st_nxt.ind.sector_mask = 3'h0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '{fsm: ST_IDLE, op: issr_pkg::ISSR_OP_SAVE, ind: issr_pkg::IND_RESET,
                      default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // The port carries only item mark and data bits, so word marks cannot change
    assign mem_wr_o = st_r.wr;
    assign mem_rd_o = st_r.rd;
    assign mem_addr_o = st_r.maddr;
    assign mem_wdata_o = st_r.wdata;
    assign ind_o = st_r.ind;
    assign instr_sequence_reg_o = st_r.sr;
    assign busy_o = st_r.fsm != ST_IDLE;
    assign done_o = st_r.fsm == ST_DONE;

    // Checks: per-command access counts
    logic [3:0] hlp_cnt_r;
    logic [ADDR_W-1:0] hlp_base_r;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hlp_cnt_r <= 4'h0;
            hlp_base_r <= '0;
        end else if (start_i && st_r.fsm == ST_IDLE) begin
            hlp_cnt_r <= 4'h0;
            hlp_base_r <= (cmd_i.op == issr_pkg::ISSR_OP_SAVE) ? sel_addr_i + ADDR_W'(1)
                : a_addr_i;
        end else if (mem_wr_o || (mem_rd_o && st_r.op == issr_pkg::ISSR_OP_RESTORE)) begin
            hlp_cnt_r <= hlp_cnt_r + 4'h1;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence save_scan_hit;
        st_r.fsm == ST_RD_DATA && st_r.op == issr_pkg::ISSR_OP_SAVE && mem_rdata_i.wm;
    endsequence
    sequence save_finish;
        st_r.fsm == ST_DONE && instr_sequence_reg_o == $past(st_r.ptr);
    endsequence

    save_count_a: assert property (done_o && st_r.op == issr_pkg::ISSR_OP_SAVE
        |-> hlp_cnt_r == 4'($countones(st_r.sel)))
        else $error("save wrote a wrong number of characters");
    save_order_a: assert property (mem_wr_o
        |-> mem_addr_o == hlp_base_r + ADDR_W'(hlp_cnt_r))
        else $error("save character at wrong address");
    scan_resume_a: assert property (save_scan_hit |=> save_finish)
        else $error("save did not resume at the word-marked location");
    source_char_a: assert property (mem_wr_o && st_r.idx == issr_pkg::IDX_SOURCE
        && !$past(st_r.ind.external_int_mode)
        |-> mem_wdata_o.b1 && !mem_wdata_o.b2 && !mem_wdata_o.b4 && !mem_wdata_o.im)
        else $error("source character wrong outside external mode");
    restore_count_a: assert property (done_o && st_r.op == issr_pkg::ISSR_OP_RESTORE
        |-> hlp_cnt_r == 4'($countones(st_r.sel[issr_pkg::RST_SEL_W-1:0]))
        && hlp_cnt_r <= 4'(issr_pkg::RST_MAX))
        else $error("restore read a wrong number of characters");
    protect_on_a: assert property ($rose(ind_o.protect) || $rose(ind_o.proceed)
        |-> $past(st_r.fsm == ST_RD_DATA && st_r.op == issr_pkg::ISSR_OP_RESTORE
        && st_r.idx == issr_pkg::IDX_PROT))
        else $error("protect or proceed turned on without a restore");
    variant_keep_a: assert property ($changed(ind_o.variant)
        |-> $past(evt_i.variant_load || (st_r.fsm == ST_RD_DATA
        && st_r.op == issr_pkg::ISSR_OP_RESTORE && st_r.idx == issr_pkg::IDX_VARIANT)))
        else $error("variant register changed without selection");
    leave_copy_a: assert property (evt_i.leave_ext && !evt_i.arith_load
        |=> ind_o.arith == $past(ind_o.aux))
        else $error("auxiliary register not copied on leaving external mode");
    no_aux_copy_a: assert property (evt_i.int_enter && !evt_i.ext_enter
        && !(st_r.fsm inside {ST_SAVE, ST_RD_DATA}) |=> $stable(ind_o.aux))
        else $error("internal interrupt changed the auxiliary register");
endmodule : issr_unit

// >>> testbench/issr_mem.sv
// Character memory model with word marks, facing the save/restore unit
`timescale 1ns/1ns
module issr_mem #(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire issr_pkg::issr_char_type wdata_i,
    output issr_pkg::issr_rchar_type rdata_o
);
    issr_pkg::issr_rchar_type mem [2**ADDR_W];
    logic rd_d = 1'b0;
    initial rdata_o = '0;
    always @(posedge core_clk_i) begin
        rd_d <= rd_i;
        // Word mark is kept: a write carries the item-mark and data bits only
        if (wr_i) mem[addr_i].ch <= wdata_i;
        // Read data stand one cycle; afterwards they flip so stale data cannot pass
        if (rd_i) rdata_o <= mem[addr_i];
        else if (rd_d) rdata_o <= ~rdata_o;
    end
endmodule : issr_mem

// >>> testbench/test_interrupt_status_save_restore.sv
// Self-checking bench of the status save/restore unit against a character memory
`timescale 1ns/1ns
module test_interrupt_status_save_restore;
    localparam int AW = 8;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start_i = 1'b0;
    issr_pkg::issr_cmd_type cmd_i = '0;
    logic [AW-1:0] sel_addr_i = '0, a_addr_i = '0, next_instr_i = '0;
    issr_pkg::issr_evt_type evt_i = '0;
    issr_pkg::issr_arith_type arith_val_i = '0, a1, a2;
    logic [5:0] variant_val_i = '0, v;
    issr_pkg::issr_rchar_type mem_rdata_i, c[5];
    logic busy_o, done_o, mem_rd_o, mem_wr_o;
    logic [AW-1:0] mem_addr_o, instr_sequence_reg_o;
    issr_pkg::issr_char_type mem_wdata_o;
    issr_pkg::issr_ind_type ind_o;
    logic [6:0] exp_q[$];
    int n_mismatch = 0, checked = 0, cyc;
    always #25 core_clk_i = ~core_clk_i;
    issr_unit #(.ADDR_W(AW)) dut (.core_clk_i, .rst_n_i, .start_i, .cmd_i, .sel_addr_i, .a_addr_i,
        .next_instr_i, .evt_i, .arith_val_i, .variant_val_i, .mem_rdata_i, .busy_o, .done_o,
        .mem_rd_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o, .ind_o, .instr_sequence_reg_o);
    issr_mem #(.ADDR_W(AW)) mem (.core_clk_i, .rd_i(mem_rd_o), .wr_i(mem_wr_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    task automatic wrap_up;
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Code 2'h2 is no address mode, so it is folded onto four-character
    function automatic logic [6:0] legal(input logic [6:0] x);
        legal = x;
        if (x[5:4] == 2'h2) legal[5:4] = 2'h3;
    endfunction : legal
    task automatic ev(input issr_pkg::issr_evt_type e, input logic [6:0] a);
        @(posedge core_clk_i);
        evt_i <= e;
        arith_val_i <= a;
        variant_val_i <= v;
        @(posedge core_clk_i);
        evt_i <= '0;
        // Indicators update on the edge just passed; look at them once settled
        @(negedge core_clk_i);
    endtask : ev
    task automatic go(input logic op, input logic [5:0] s, input logic [AW-1:0] ad);
        @(posedge core_clk_i);
        start_i <= 1'b1;
        cmd_i <= {op, s};
        sel_addr_i <= ad;
        a_addr_i <= ad;
        next_instr_i <= ad + 8'h40;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        cyc = -1;
        do begin
            @(negedge core_clk_i);
            cyc++;
        end while (done_o !== 1'b1 && cyc < 99);
        if (cyc >= 99) begin
            n_mismatch++;
            wrap_up;
        end
        chk(16'({busy_o, mem_rd_o, mem_wr_o}), 16'h0004);
    endtask : go
    initial begin
        void'($urandom(8));
        for (int i = 0; i < 256; i++) mem.mem[i] = {1'b0, 7'($urandom)};
        mem.mem[17].wm = 1'b1;
        mem.mem[25].wm = 1'b1;
        mem.mem[66].wm = 1'b1;
        a1 = legal(7'($urandom));
        a2 = legal(7'($urandom));
        v = 6'($urandom);
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        ev(13'h0180, a1);
        // External entry with address violation, monitor, console and peripheral sources
        ev(13'h1078, a1);
        ev(13'h0100, a2);
        go(1'b0, 6'h3F, 8'h10);
        chk(16'(cyc), 16'h0010);
        chk(16'(instr_sequence_reg_o), 16'h0019);
        exp_q = '{{1'b0, v}, a2, a1, 7'h00, 7'h00, 7'h3E};
        foreach (exp_q[i]) chk(16'(mem.mem[17 + i]), {8'h00, i == 0, exp_q[i]});
        chk({ind_o.arith, ind_o.aux}, {a2 & 7'h70, a1 & 7'h70});
        chk({ind_o.variant, ind_o.ext_addr_viol, ind_o.console_int}, {v, 2'h0});
        for (int i = 0; i < 5; i++) begin
            c[i] = {1'($urandom), legal(7'($urandom))};
            mem.mem[48 + i] = c[i];
        end
        go(1'b1, 6'h3F, 8'h30);
        chk(16'(cyc), 16'h0010);
        chk(16'(instr_sequence_reg_o), 16'h0070);
        chk({ind_o.variant, ind_o.arith}, {c[0].ch[5:0], c[1].ch});
        chk({ind_o.aux, ind_o.ext_io, ind_o.multiprog_flag_a},
            {c[2].ch, c[3].ch[6:5]});
        chk({ind_o.multiprog_flag_b, ind_o.multiprog_flag_c,
            ind_o.sector_mask}, {c[3].ch[4:3], c[3].ch.b1, c[3].ch.b2, c[3].ch.b4});
        chk({ind_o.protect, ind_o.timeout_allow, ind_o.s_mode, ind_o.proceed},
            c[4].ch[5:2]);
        chk({ind_o.relocation, ind_o.internal_int_mode}, c[4].ch[1:0]);
        for (int i = 0; i < 5; i++) chk(16'(mem.mem[48 + i]), 16'(c[i]));
        ev(13'h0400, c[1].ch);
        chk({ind_o.arith, ind_o.external_int_mode}, {c[2].ch, 1'b0});
        // Internal entry with address and op code violations
        ev(13'h0806, c[1].ch);
        go(1'b0, 6'h20, 8'h40);
        chk(16'(cyc), 16'h0005);
        chk(16'(instr_sequence_reg_o), 16'h0042);
        chk(16'(mem.mem[65]), 16'h0031);
        chk({ind_o.aux, ind_o.int_addr_viol, ind_o.opcode_viol},
            {c[2].ch, 2'h0});
        wrap_up;
    end
endmodule : test_interrupt_status_save_restore
